// *** core/emacc_config_regs.sv ***
// Accumulation mode, gain and zero-crossing enable registers.
//
// Behaviour
// (R01) Bit 7 reports tamper current input, A=0, B=1.
// (R02) Fault event on entering fault, or leaving it.
// (R03) Reactive sign event direction chosen by bit 5.
// (R04) Active sign event direction chosen by bit 4.
// (R05) Bit 3: absolute reactive power accumulated.
// (R06) Bit 2: reactive sign follows active power sign.
// (R07) Signed reactive mode feeds every reactive consumer.
// (R08) Bit 1: only positive active power accumulated.
// (R09) Bit 0: absolute active power accumulated.
// (R10) Gain bits 7:5 set voltage gain 1..16.
// (R11) Gain bits 2:0 set current gain 1..16.
// (R12) Gain bit 3 picks filtered or per-pulse sign.
// (R13) Enable bit 1 drives first zero-crossing pin.
// (R14) Enable bit 0 drives second zero-crossing pin.
// (R15) Sign and fault flags set on chosen transition.
// (R16) Reserved bits read zero; fields reset to zero.
// (R17) Software writes only gain codes 0 to 4.
`timescale 1ns/10ps
module emacc_config_regs (
   input wire logic core_clk,
   input wire logic resetn,
   // Avalon-MM slave, byte addressed.
   input wire logic [emacc_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [emacc_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [emacc_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   // Measurement side, all on core_clk.
   input wire emacc_pkg::emacc_meas_t measIn,
   input wire logic faultMode,
   input wire logic tamperUsesInputB,
   input wire logic cfPulse,
   input wire logic zeroCross,
   output emacc_pkg::emacc_meas_t accumOut,
   output logic [2:0] voltageGainShift,
   output logic [2:0] currentGainShift,
   output logic signPerPulse,
   output emacc_pkg::emacc_pin_t zxPinFirst,
   output emacc_pkg::emacc_pin_t zxPinSecond,
   output logic irq
);

   // True when a byte address selects the register with the given index.
   function automatic logic regHit(input logic [emacc_pkg::ADDR_W-1:0] addr,
                                   input logic [7:0] idx);
      logic [9:0] byteAddr;
      byteAddr = {idx, 2'b00};
      regHit = (addr == byteAddr[emacc_pkg::ADDR_W-1:0]);
   endfunction

   // Gain code to left shift; undefined codes give unity gain.
   function automatic logic [2:0] gainShift(input logic [2:0] code);
      if (code <= emacc_pkg::GAIN_CODE_MAX) begin
         gainShift = code;
      end else begin
         gainShift = 3'h0;
      end
   endfunction

   // Software-visible storage.
   logic [7:0] accumulation_mode_q; // Accumulation mode, writable bits 6:0.
   logic [7:0] gain_q; // Channel gain codes and sign source.
   logic [7:0] zxEnable_q; // Zero-crossing output enables.
   logic [7:0] irqStatus_q; // Sticky event flags.
   logic [7:0] irqMask_q; // Event enables onto the interrupt line.
   logic [7:0] irqStatus_d; // Next value of the sticky flags.
   logic tamperB_q; // Latched current input in use.

   // Bus handshake state.
   emacc_pkg::emacc_bus_t busState_q;
   logic waitReq_q;
   logic [emacc_pkg::DATA_W-1:0] readData_q;
   logic writeTaken; // High on the edge at which a write is accepted.
   logic [7:0] wrByte; // Low byte of the write data.

   // Sign tracking.
   logic activeNeg; // Active power below zero this cycle.
   logic reactiveNeg; // Reactive power below zero this cycle.
   logic signStrobe; // Moment at which sign is evaluated.
   logic [emacc_pkg::EV_COUNT-1:0] events;

   // Conditioned power values before registering.
   emacc_pkg::emacc_meas_t accum_d;

   // Output registers.
   emacc_pkg::emacc_meas_t accum_q;
   logic [2:0] voltShift_q;
   logic [2:0] currShift_q;
   logic signPerPulse_q;
   emacc_pkg::emacc_pin_t zxFirst_q;
   emacc_pkg::emacc_pin_t zxSecond_q;
   logic irq_q;

   assign wrByte = avs_writedata[emacc_pkg::REG_W-1:0];
   assign writeTaken = avs_write && !waitReq_q && avs_byteenable[0];

   // Handshake: waitrequest drops for one cycle after a request is seen.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         busState_q <= emacc_pkg::EMACC_BUS_IDLE;
         waitReq_q <= 1'b1;
      end else begin
         unique case (busState_q)
            emacc_pkg::EMACC_BUS_IDLE: begin
               // A request moves to the answer cycle.
               if (avs_read || avs_write) begin
                  busState_q <= emacc_pkg::EMACC_BUS_ACK;
                  waitReq_q <= 1'b0;
               end
            end
            emacc_pkg::EMACC_BUS_ACK: begin
               // The master samples waitrequest low here and releases.
               busState_q <= emacc_pkg::EMACC_BUS_IDLE;
               waitReq_q <= 1'b1;
            end
            default: begin
               busState_q <= emacc_pkg::EMACC_BUS_IDLE;
               waitReq_q <= 1'b1;
            end
         endcase
      end
   end

   // Read data are captured when a read is seen idle.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         readData_q <= '0;
      end else if (avs_read && busState_q == emacc_pkg::EMACC_BUS_IDLE) begin
         // Unmapped addresses and reserved bits read as zero.
         readData_q <= '0; // R16
         if (regHit(avs_address, emacc_pkg::IDX_ACC_MODE)) begin
            readData_q[7:0] <= {tamperB_q, accumulation_mode_q[6:0]}; // R01
         end else if (regHit(avs_address, emacc_pkg::IDX_CHANNEL_GAIN)) begin
            readData_q[7:0] <= gain_q;
         end else if (regHit(avs_address, emacc_pkg::IDX_ZX_ENABLE)) begin
            readData_q[7:0] <= zxEnable_q;
         end else if (regHit(avs_address, emacc_pkg::IDX_IRQ_STATUS)) begin
            readData_q[7:0] <= irqStatus_q;
         end else if (regHit(avs_address, emacc_pkg::IDX_IRQ_MASK)) begin
            readData_q[7:0] <= irqMask_q;
         end else if (regHit(avs_address, emacc_pkg::IDX_LIVE_STATE)) begin
            // Live view of the tracked signs and fault level.
            readData_q[emacc_pkg::EV_ACTIVE_SIGN] <= activeNeg;
            readData_q[emacc_pkg::EV_REACT_SIGN] <= reactiveNeg;
            readData_q[emacc_pkg::EV_FAULT] <= faultMode;
         end
      end
   end

   // The tamper input in use is a read-only status copied every cycle.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         tamperB_q <= 1'b0;
      end else begin
         tamperB_q <= tamperUsesInputB; // R01
      end
   end

   // Accumulation mode register; bit 7 is not stored, it is live state.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         accumulation_mode_q <= emacc_pkg::REG_RESET; // R16
      end else if (writeTaken && regHit(avs_address, emacc_pkg::IDX_ACC_MODE)) begin
         accumulation_mode_q <= wrByte & emacc_pkg::ACC_WR_MASK;
      end
   end

   // Gain register; reserved bit 4 never stores a one.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         gain_q <= emacc_pkg::REG_RESET; // R16
      end else if (writeTaken && regHit(avs_address, emacc_pkg::IDX_CHANNEL_GAIN)) begin
         gain_q <= wrByte & emacc_pkg::GAIN_WR_MASK; // R16
      end
   end

   // Zero-crossing enable register; bits 7:2 are reserved.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         zxEnable_q <= emacc_pkg::REG_RESET; // R16
      end else if (writeTaken && regHit(avs_address, emacc_pkg::IDX_ZX_ENABLE)) begin
         zxEnable_q <= wrByte & emacc_pkg::ZX_WR_MASK; // R16
      end
   end

   // Interrupt mask register, same layout as the status register.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         irqMask_q <= emacc_pkg::REG_RESET;
      end else if (writeTaken && regHit(avs_address, emacc_pkg::IDX_IRQ_MASK)) begin
         irqMask_q <= wrByte & emacc_pkg::IRQ_WR_MASK;
      end
   end

   // Sign of each power value; zero counts as positive.
   assign activeNeg = measIn.active[emacc_pkg::MEAS_W-1];
   assign reactiveNeg = measIn.reactive[emacc_pkg::MEAS_W-1];

   // Signs are checked every cycle, or only on each frequency-output pulse.
   assign signStrobe = gain_q[emacc_pkg::GAIN_SIGN_SRC_BIT] ? cfPulse : 1'b1; // R12

   // One transition detector per event.
   genvar g;
   generate
      for (g = 0; g < emacc_pkg::EV_COUNT; g++) begin : gEvent
         logic level;
         logic strobe;
         logic selFall;
         if (g == emacc_pkg::EV_ACTIVE_SIGN) begin : gActive
            assign level = activeNeg;
            assign strobe = signStrobe;
            assign selFall = accumulation_mode_q[emacc_pkg::ACC_ACTIVE_SEL_BIT]; // R04
         end else if (g == emacc_pkg::EV_REACT_SIGN) begin : gReact
            assign level = reactiveNeg;
            assign strobe = signStrobe;
            assign selFall = accumulation_mode_q[emacc_pkg::ACC_REACT_SEL_BIT]; // R03
         end else begin : gFault
            assign level = faultMode;
            assign strobe = 1'b1;
            assign selFall = accumulation_mode_q[emacc_pkg::ACC_FAULT_SEL_BIT]; // R02
         end
         emacc_edge_event uDetect (
            .core_clk(core_clk),
            .resetn(resetn),
            .sampleLevel(level),
            .sampleStrobe(strobe),
            .selectFalling(selFall),
            .eventPulse(events[g])
         );
      end
   endgenerate

   // Sticky flags: a new event wins over a clear.
   always_comb begin
      irqStatus_d = irqStatus_q;
      if (writeTaken && regHit(avs_address, emacc_pkg::IDX_IRQ_STATUS)) begin
         irqStatus_d = irqStatus_q & ~(wrByte & emacc_pkg::IRQ_WR_MASK);
      end
      irqStatus_d[emacc_pkg::EV_COUNT-1:0] = irqStatus_d[emacc_pkg::EV_COUNT-1:0] | events; // R15
   end

   // Stores the flags and forms the level interrupt from the unmasked ones.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         irqStatus_q <= emacc_pkg::REG_RESET;
         irq_q <= 1'b0;
      end else begin
         irqStatus_q <= irqStatus_d;
         irq_q <= |(irqStatus_d & irqMask_q);
      end
   end

   // Conditions power before any accumulator.
   always_comb begin
      accum_d = measIn;
      // Absolute value takes priority over positive-only when both are set.
      if (accumulation_mode_q[emacc_pkg::ACC_ACTIVE_ABS_BIT]) begin
         if (activeNeg) begin
            accum_d.active = -measIn.active; // R09
         end
      end else if (accumulation_mode_q[emacc_pkg::ACC_ACTIVE_POS_BIT]) begin
         if (activeNeg) begin
            accum_d.active = '0; // R08
         end
      end
      // Absolute reactive takes priority over the sign-by-active mode.
      if (accumulation_mode_q[emacc_pkg::ACC_REACT_ABS_BIT]) begin
         if (reactiveNeg) begin
            accum_d.reactive = -measIn.reactive; // R05
         end
      end else if (accumulation_mode_q[emacc_pkg::ACC_REACT_SBA_BIT]) begin
         if (activeNeg) begin
            accum_d.reactive = -measIn.reactive; // R06
         end
      end
   end

   // One conditioned value drives the energy, line-cycle and pulse paths alike.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         accum_q <= '0;
      end else begin
         accum_q <= accum_d; // R07
      end
   end

   // Gain shifts for the two input channels and the sign source flag.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         voltShift_q <= 3'h0;
         currShift_q <= 3'h0;
         signPerPulse_q <= 1'b0;
      end else begin
         voltShift_q <= gainShift(gain_q[emacc_pkg::GAIN_VOLT_HI:emacc_pkg::GAIN_VOLT_LO]); // R10
         currShift_q <= gainShift(gain_q[emacc_pkg::GAIN_CURR_HI:emacc_pkg::GAIN_CURR_LO]); // R11
         signPerPulse_q <= gain_q[emacc_pkg::GAIN_SIGN_SRC_BIT]; // R12
      end
   end

   // Zero-crossing pins drive the crossing level only while enabled.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         zxFirst_q <= '0;
         zxSecond_q <= '0;
      end else begin
         zxFirst_q.enable <= zxEnable_q[emacc_pkg::ZX_FIRST_BIT]; // R13
         zxFirst_q.level <= zxEnable_q[emacc_pkg::ZX_FIRST_BIT] & zeroCross; // R13
         zxSecond_q.enable <= zxEnable_q[emacc_pkg::ZX_SECOND_BIT]; // R14
         zxSecond_q.level <= zxEnable_q[emacc_pkg::ZX_SECOND_BIT] & zeroCross; // R14
      end
   end

   // Every output comes straight from a register.
   assign avs_readdata = readData_q;
   assign avs_waitrequest = waitReq_q;
   assign accumOut = accum_q;
   assign voltageGainShift = voltShift_q;
   assign currentGainShift = currShift_q;
   assign signPerPulse = signPerPulse_q;
   assign zxPinFirst = zxFirst_q;
   assign zxPinSecond = zxSecond_q;
   assign irq = irq_q;

endmodule

// *** core/emacc_edge_event.sv ***
// Raises a one-cycle event on a selected change of a sampled level.
`timescale 1ns/10ps
module emacc_edge_event (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic sampleLevel,
   input wire logic sampleStrobe,
   input wire logic selectFalling,
   output logic eventPulse
);

   // Level seen at the last sample and a flag that a first sample exists.
   logic prevLevel_q;
   logic primed_q;

   // Keeps the last sampled level; the first sample after reset only primes it.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         prevLevel_q <= 1'b0;
         primed_q <= 1'b0;
      end else if (sampleStrobe) begin
         prevLevel_q <= sampleLevel;
         primed_q <= 1'b1;
      end
   end

   // A change counts only when the new level matches the chosen direction.
   always_comb begin
      eventPulse = sampleStrobe && primed_q && (sampleLevel != prevLevel_q)
                   && (sampleLevel == !selectFalling);
   end

endmodule

// *** inc/emacc_pkg.sv ***
// Register map, field layout and carrier types.
package emacc_pkg;

   // Bus widths; registers sit in the low byte of a word.
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;
   localparam int MEAS_W = 24;

   // Register indices; byte address is four times the index.
   localparam logic [7:0] IDX_ACC_MODE = 8'h0F;
   localparam logic [7:0] IDX_CHANNEL_GAIN = 8'h1B;
   localparam logic [7:0] IDX_ZX_ENABLE = 8'h2B;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h31;
   localparam logic [7:0] IDX_LIVE_STATE = 8'h32;

   // Field positions of the accumulation mode register.
   localparam int ACC_TAMPER_CH_BIT = 7;
   localparam int ACC_FAULT_SEL_BIT = 6;
   localparam int ACC_REACT_SEL_BIT = 5;
   localparam int ACC_ACTIVE_SEL_BIT = 4;
   localparam int ACC_REACT_ABS_BIT = 3;
   localparam int ACC_REACT_SBA_BIT = 2;
   localparam int ACC_ACTIVE_POS_BIT = 1;
   localparam int ACC_ACTIVE_ABS_BIT = 0;

   // Field positions of the channel gain register.
   localparam int GAIN_VOLT_HI = 7;
   localparam int GAIN_VOLT_LO = 5;
   localparam int GAIN_SIGN_SRC_BIT = 3;
   localparam int GAIN_CURR_HI = 2;
   localparam int GAIN_CURR_LO = 0;
   localparam logic [2:0] GAIN_CODE_MAX = 3'h4;

   // Field positions of the zero-crossing output enable register.
   localparam int ZX_FIRST_BIT = 1;
   localparam int ZX_SECOND_BIT = 0;

   // Writable bits of each register.
   localparam logic [7:0] ACC_WR_MASK = 8'h7F;
   localparam logic [7:0] GAIN_WR_MASK = 8'hEF;
   localparam logic [7:0] ZX_WR_MASK = 8'h03;
   localparam logic [7:0] IRQ_WR_MASK = 8'h07;
   localparam logic [7:0] REG_RESET = 8'h00;

   // Event bit positions shared by the status and mask registers.
   localparam int EV_ACTIVE_SIGN = 0;
   localparam int EV_REACT_SIGN = 1;
   localparam int EV_FAULT = 2;
   localparam int EV_COUNT = 3;

   // Bus handshake states.
   typedef enum logic [1:0] {
      EMACC_BUS_IDLE = 2'b00,
      EMACC_BUS_ACK = 2'b01
   } emacc_bus_t;

   // One pair of power samples, active and reactive, in two's complement.
   typedef struct packed {
      logic signed [MEAS_W-1:0] active;
      logic signed [MEAS_W-1:0] reactive;
   } emacc_meas_t;

   // Zero-crossing pin drive, level and output enable.
   typedef struct packed {
      logic level;
      logic enable;
   } emacc_pin_t;

endpackage

// *** verif/emacc_config_regs_props.sv ***
// Concurrent checks on the ports of the configuration register block.
`timescale 1ns/10ps
module emacc_config_regs_props (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [emacc_pkg::DATA_W-1:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire emacc_pkg::emacc_meas_t measIn,
   input wire logic zeroCross,
   input wire emacc_pkg::emacc_meas_t accumOut,
   input wire logic [2:0] voltageGainShift,
   input wire logic [2:0] currentGainShift,
   input wire emacc_pkg::emacc_pin_t zxPinFirst,
   input wire emacc_pkg::emacc_pin_t zxPinSecond
);
   // Core clock; checks rest during reset.
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   // An idle request is answered after one wait cycle.
   a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest did not drop one cycle after a request");
   // The answer lasts a single cycle.
   a_wait_low_once: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest stayed low for more than one cycle");
   // With no request the slave never answers.
   a_wait_idle_quiet: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest dropped without a request");
   // Only the low byte of a word carries register content.
   a_read_upper_zero: assert property (avs_readdata[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   // Read data changes only when a read is taken.
   a_read_data_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
      else $error("read data changed without a read");
   // Conditioned active power is the sample, its magnitude or zero.
   a_active_shape: assert property ($past(resetn) |-> accumOut.active == $past(measIn.active)
      || accumOut.active == -$past(measIn.active) || accumOut.active == 24'h000000)
      else $error("conditioned active power not derived from the sample");
   // Conditioned reactive power is the sample or its negation.
   a_react_shape: assert property ($past(resetn) |-> accumOut.reactive == $past(measIn.reactive)
      || accumOut.reactive == -$past(measIn.reactive))
      else $error("conditioned reactive power not derived from the sample");
   // Gain shifts never exceed the largest defined code.
   a_gain_in_range: assert property (voltageGainShift <= 3'h4 && currentGainShift <= 3'h4)
      else $error("gain shift above the largest code");
   // First pin: quiet while off, follows the crossing when on.
   a_zx_first_off: assert property (!zxPinFirst.enable && !$past(zxPinFirst.enable) |-> !zxPinFirst.level)
      else $error("first crossing pin active while disabled");
   a_zx_first_follow: assert property (zxPinFirst.enable && $past(zxPinFirst.enable)
      |-> zxPinFirst.level == $past(zeroCross))
      else $error("first crossing pin does not follow the crossing level");
   // The second pin behaves the same under its own enable.
   a_zx_second_off: assert property (!zxPinSecond.enable && !$past(zxPinSecond.enable) |-> !zxPinSecond.level)
      else $error("second crossing pin active while disabled");
   a_zx_second_follow: assert property (zxPinSecond.enable && $past(zxPinSecond.enable)
      |-> zxPinSecond.level == $past(zeroCross))
      else $error("second crossing pin does not follow the crossing level");
endmodule

bind emacc_config_regs emacc_config_regs_props u_props (.core_clk(core_clk), .resetn(resetn),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .measIn(measIn), .zeroCross(zeroCross),
   .accumOut(accumOut), .voltageGainShift(voltageGainShift), .currentGainShift(currentGainShift),
   .zxPinFirst(zxPinFirst), .zxPinSecond(zxPinSecond));

// *** verif/emacc_config_regs_tb.sv ***
// Testbench for the configuration register block.
`timescale 1ns/10ps
module emacc_config_regs_tb;
   logic core_clk = 1'b0; // Core clock, 20 ns period.
   logic resetn = 1'b0; // Active-low reset, held for 20 cycles.
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [3:0] avs_byteenable = 4'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   emacc_pkg::emacc_meas_t measIn = '0; // Power samples driven by the bench.
   logic faultMode = 1'b0;
   logic tamperUsesInputB = 1'b0;
   logic cfPulse = 1'b0;
   logic zeroCross = 1'b0;
   emacc_pkg::emacc_meas_t accumOut;
   logic [2:0] voltageGainShift;
   logic [2:0] currentGainShift;
   logic signPerPulse;
   emacc_pkg::emacc_pin_t zxPinFirst;
   emacc_pkg::emacc_pin_t zxPinSecond;
   logic irq;
   int nErrors = 0; // Mismatches seen.
   int checkCount = 0; // Comparisons made.
   // Conditioning cases: mode, input pair {active, reactive} and expected pair.
   logic [7:0] tMode [8] = '{8'h00, 8'h01, 8'h02, 8'h02, 8'h08, 8'h04, 8'h04, 8'h0C};
   logic [47:0] tIn [8] = '{48'hFFFFFB_FFFFFD, 48'hFFFFFB_FFFFFD, 48'hFFFFFB_000003,
      48'h000007_FFFFFD, 48'hFFFFFB_FFFFFD, 48'hFFFFFB_000003, 48'h000005_FFFFFD,
      48'hFFFFFB_FFFFFD};
   logic [47:0] tExp [8] = '{48'hFFFFFB_FFFFFD, 48'h000005_FFFFFD, 48'h000000_000003,
      48'h000007_FFFFFD, 48'hFFFFFB_000003, 48'hFFFFFB_FFFFFD, 48'h000005_FFFFFD,
      48'hFFFFFB_000003};

   emacc_config_regs u_dut (.core_clk(core_clk), .resetn(resetn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .measIn(measIn), .faultMode(faultMode),
      .tamperUsesInputB(tamperUsesInputB), .cfPulse(cfPulse), .zeroCross(zeroCross),
      .accumOut(accumOut), .voltageGainShift(voltageGainShift),
      .currentGainShift(currentGainShift), .signPerPulse(signPerPulse),
      .zxPinFirst(zxPinFirst), .zxPinSecond(zxPinSecond), .irq(irq));

   // Free-running core clock.
   always #10 core_clk = ~core_clk;

   // Prints the counts and the verdict, then ends the run.
   task automatic printVerdict();
      $display("Comparisons %0d, mismatches %0d", checkCount, nErrors);
      if (nErrors == 0 && checkCount > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Compares one value and reports a mismatch at once.
   task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
      checkCount++;
      if (got !== exp) begin
         nErrors++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One transfer, held until waitrequest is sampled low.
   task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wdata,
                      input logic [3:0] be, output logic [7:0] rdata);
      int n;
      n = 0;
      avs_address <= {idx[5:0], 2'b00};
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= {24'h000000, wdata};
      avs_byteenable <= be;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0) begin
         n++;
         if (n > 50) begin
            nErrors++;
            printVerdict();
         end
         @(posedge core_clk);
      end
      rdata = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge core_clk);
   endtask

   // Register write with the low byte enabled.
   task automatic wr(input logic [7:0] idx, input logic [7:0] data);
      logic [7:0] unused;
      bus(idx, 1'b1, data, 4'h1, unused);
   endtask

   // Register read compared with an expected byte.
   task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input string name);
      logic [7:0] v;
      bus(idx, 1'b0, 8'h00, 4'h1, v);
      chk(name, 48'(exp), 48'(v));
   endtask

   // Drives one event source asserted or released.
   task automatic drive_ev(input int ev, input logic on);
      case (ev)
         0: measIn.active <= on ? 24'hFFFFFF : 24'h000001;
         1: measIn.reactive <= on ? 24'hFFFFFF : 24'h000001;
         default: faultMode <= on;
      endcase
   endtask

   // Main sequence.
   initial begin
      repeat (20) @(posedge core_clk);
      resetn <= 1'b1;
      @(posedge core_clk);
      rd(emacc_pkg::IDX_ACC_MODE, 8'h00, "mode reset");
      rd(emacc_pkg::IDX_CHANNEL_GAIN, 8'h00, "gain reset");
      rd(emacc_pkg::IDX_ZX_ENABLE, 8'h00, "zx reset");
      rd(8'h10, 8'h00, "unmapped read");
      // Indicator bit mirrors the tamper input and ignores writes.
      wr(emacc_pkg::IDX_ACC_MODE, 8'hFF);
      rd(emacc_pkg::IDX_ACC_MODE, 8'h7F, "mode input A");
      tamperUsesInputB <= 1'b1;
      repeat (2) @(posedge core_clk);
      rd(emacc_pkg::IDX_ACC_MODE, 8'hFF, "mode input B");
      // Conditioning of the power samples for each accumulation mode.
      for (int i = 0; i < 8; i++) begin
         wr(emacc_pkg::IDX_ACC_MODE, tMode[i]);
         measIn <= tIn[i];
         repeat (2) @(posedge core_clk);
         chk("conditioned power", tExp[i], accumOut);
      end
      // Gain fields for every defined code, reserved bit kept at zero.
      wr(emacc_pkg::IDX_CHANNEL_GAIN, 8'hFF);
      rd(emacc_pkg::IDX_CHANNEL_GAIN, 8'hEF, "gain reserved");
      for (int c = 0; c < 5; c++) begin
         wr(emacc_pkg::IDX_CHANNEL_GAIN, {3'(c), 1'b0, 1'(c), 3'(4 - c)});
         repeat (2) @(posedge core_clk);
         chk("voltage shift", 48'(c), 48'(voltageGainShift));
         chk("current shift", 48'(4 - c), 48'(currentGainShift));
         chk("sign source", 48'(c % 2), 48'(signPerPulse));
      end
      // Zero-crossing pins for every enable pattern and both crossing levels.
      wr(emacc_pkg::IDX_ZX_ENABLE, 8'hFF);
      rd(emacc_pkg::IDX_ZX_ENABLE, 8'h03, "zx reserved");
      for (int e = 0; e < 4; e++) begin
         wr(emacc_pkg::IDX_ZX_ENABLE, 8'(e));
         for (int z = 0; z < 2; z++) begin
            zeroCross <= z[0];
            repeat (3) @(posedge core_clk);
            chk("first pin", 48'({e[1] & z[0], e[1]}), 48'(zxPinFirst));
            chk("second pin", 48'({e[0] & z[0], e[0]}), 48'(zxPinSecond));
         end
      end
      wr(emacc_pkg::IDX_ZX_ENABLE, 8'h00);
      begin
         logic [7:0] unused;
         bus(emacc_pkg::IDX_ZX_ENABLE, 1'b1, 8'h03, 4'h0, unused);
      end
      rd(emacc_pkg::IDX_ZX_ENABLE, 8'h00, "masked write ignored");
      // Sign and fault events for both transition selects, with mask and clear.
      wr(emacc_pkg::IDX_CHANNEL_GAIN, 8'h00);
      wr(emacc_pkg::IDX_IRQ_MASK, 8'h07);
      rd(emacc_pkg::IDX_IRQ_MASK, 8'h07, "mask readback");
      for (int ev = 0; ev < 3; ev++) begin
         for (int sel = 0; sel < 2; sel++) begin
            drive_ev(ev, !sel[0]);
            wr(emacc_pkg::IDX_ACC_MODE, 8'(sel << (4 + ev)));
            repeat (3) @(posedge core_clk);
            wr(emacc_pkg::IDX_IRQ_STATUS, 8'h07);
            drive_ev(ev, sel[0]);
            repeat (3) @(posedge core_clk);
            rd(emacc_pkg::IDX_IRQ_STATUS, 8'h00, "other edge ignored");
            drive_ev(ev, !sel[0]);
            repeat (3) @(posedge core_clk);
            rd(emacc_pkg::IDX_IRQ_STATUS, 8'(1 << ev), "chosen edge flag");
            chk("irq raised", 48'h1, 48'(irq));
            wr(emacc_pkg::IDX_IRQ_MASK, 8'h00);
            repeat (2) @(posedge core_clk);
            chk("irq masked", 48'h0, 48'(irq));
            wr(emacc_pkg::IDX_IRQ_MASK, 8'h07);
            wr(emacc_pkg::IDX_IRQ_STATUS, 8'h07);
            repeat (2) @(posedge core_clk);
            chk("irq cleared", 48'h0, 48'(irq));
         end
      end
      // Per-pulse sign sampling: a sign change waits for the next pulse.
      wr(emacc_pkg::IDX_ACC_MODE, 8'h00);
      wr(emacc_pkg::IDX_CHANNEL_GAIN, 8'h08);
      drive_ev(0, 1'b1);
      repeat (3) @(posedge core_clk);
      rd(emacc_pkg::IDX_IRQ_STATUS, 8'h00, "no pulse no flag");
      cfPulse <= 1'b1;
      @(posedge core_clk);
      cfPulse <= 1'b0;
      repeat (2) @(posedge core_clk);
      rd(emacc_pkg::IDX_IRQ_STATUS, 8'h01, "flag on pulse");
      rd(emacc_pkg::IDX_LIVE_STATE, 8'h01, "live state");
      printVerdict();
   end
endmodule
